// *** hpr_pkg.sv ***
// Shared constants of the hibernation power and seconds-counter unit.
// Assumes a single 25 MHz system clock; all slower rates are enables.
`default_nettype none

package hpr_pkg;

  // Register byte offsets on the bus.
  localparam logic [8:0] OFF_COUNT = 9'h000;
  localparam logic [8:0] OFF_MATCH0 = 9'h004;
  localparam logic [8:0] OFF_MATCH1 = 9'h008;
  localparam logic [8:0] OFF_LOAD = 9'h00c;
  localparam logic [8:0] OFF_CTL = 9'h010;
  localparam logic [8:0] OFF_MASK = 9'h014;
  localparam logic [8:0] OFF_RAW = 9'h018;
  localparam logic [8:0] OFF_MASKED = 9'h01c;
  localparam logic [8:0] OFF_CLEAR = 9'h020;
  localparam logic [8:0] OFF_TRIM = 9'h024;
  localparam logic [8:0] OFF_MEM_FIRST = 9'h030;
  localparam logic [8:0] OFF_MEM_LAST = 9'h12c;

  // Control register fields.
  localparam int CTL_COUNTER_ENABLE = 0;
  localparam int CTL_SLEEP_REQUEST = 1;
  localparam int CTL_OSC_SELECT = 2;
  localparam int CTL_MATCH_WAKE_ENABLE = 3;
  localparam int CTL_PIN_WAKE_ENABLE = 4;
  localparam int CTL_LOW_BATTERY_DETECT_ENABLE = 5;
  localparam int CTL_OSC_ENABLE = 6;
  localparam int CTL_BATTERY_LOW_VETO = 7;
  localparam int CTL_WIDTH = 8;

  // Event bits of raw, masked, mask and clear registers.
  localparam int EV_MATCH_ZERO = 0;
  localparam int EV_MATCH_ONE = 1;
  localparam int EV_BATTERY_LOW = 2;
  localparam int EV_WAKE_PIN = 3;
  localparam int EV_WIDTH = 4;

  // Reset values.
  localparam logic [31:0] MATCH_RESET = 32'hffff_ffff;
  localparam logic [31:0] LOAD_RESET = 32'hffff_ffff;
  localparam logic [14:0] TRIM_NOMINAL = 15'h7fff;

  // Clock tree of the seconds counter.
  localparam logic [6:0] XTAL_DIV_LAST = 7'h7f;
  localparam logic [5:0] TRIM_SLOT_BEFORE = 6'h3f;

  // Memory geometry.
  localparam int MEM_WORDS = 64;
  localparam int MEM_AW = 6;

  // Processor reset held after a wake, in ns, and as cycles of 40 ns.
  localparam int CLK_PERIOD_NS = 40;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) /
                              CLK_PERIOD_NS;

  typedef enum logic [1:0] {PW_RUN, PW_HIB, PW_POR} hpr_pwr_t;

endpackage

`default_nettype wire

// *** hpr_retain_mem.sv ***
// Retained storage of 64 words of 32 bits, one write and one read port.
// Assumes the backup supply keeps this array alive while the core is off.
`default_nettype none

module hpr_retain_mem (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [hpr_pkg::MEM_AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [hpr_pkg::MEM_AW-1:0] rd_addr,
  output logic [31:0] rd_data
);

  logic [31:0] mem [hpr_pkg::MEM_WORDS];

  // No reset on the array: contents must survive a processor reset.
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// *** hpr_unit.sv ***
// Hibernation power unit: regulator switch, wake logic, seconds counter,
// events and retained memory behind an AHB-Lite slave.
// Assumes one 25 MHz clock; oscillator, wake and battery pins are async.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`default_nettype none

// Behaviour
// - regulator off output goes low on hibernate, high again on wake.
// - in hibernation, enabled wake pin or counter match ends it.
// - reads may follow each other with no spacing.
// - oscillator select 0 divides input by 128, 1 uses it directly.
// - slow clock runs only while oscillator enable is set.
// - with detection enabled, low battery sets the raw battery flag.
// - with veto also set, a low battery refuses hibernation.
// - 32-bit seconds counter steps per predivider period when enabled.
// - predivider counts ticks; one second in 64 uses trim value.
// - writing the load register replaces the counter at once.
// - two match registers compared continuously; wake or event.
// - 64 retained words of 32 bits readable and writable.
// - setting sleep request starts hibernation.
// - pin and match wake enables arm their sources independently.
// - after wake, processor sees reset; wake event stays pending.
// - events logged and enabled ones ORed into one request line.
// - raw status shows all pending events, any time.
// - masked status and request line show only unmasked events.
// - writing one to a clear bit clears that raw event.
// - oscillator select is bit 2 of control.
// - match event mask bits sit in bits 1:0 of mask.
module hpr_unit (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic WAKE_N,
  input wire logic OSC_IN,
  input wire logic BATT_LOW,
  output logic REGULATOR_OFF_N,
  output logic PROC_RST_N,
  output logic IRQ
);

  // Matches a latched bus address against a register offset.
  function automatic logic reg_hit(input logic [8:0] a,
                                   input logic [8:0] off);
    reg_hit = (a == off);
  endfunction

  // Word index of the retained memory for a byte address.
  function automatic logic [hpr_pkg::MEM_AW-1:0] mem_index(
    input logic [8:0] a);
    logic [8:0] d;
    d = a - hpr_pkg::OFF_MEM_FIRST;
    mem_index = d[hpr_pkg::MEM_AW+1:2];
  endfunction

  function automatic logic mem_hit(input logic [8:0] a);
    mem_hit = (a >= hpr_pkg::OFF_MEM_FIRST) &&
              (a <= hpr_pkg::OFF_MEM_LAST);
  endfunction

  logic dp_q;
  logic wr_q;
  logic [8:0] addr_q;
  logic accept;
  logic wr_en;
  logic [31:0] mem_rdata;
  logic [31:0] rdata_d;
  logic [31:0] match0_q;
  logic [31:0] match1_q;
  logic [31:0] load_q;
  logic [31:0] count_q;
  logic [14:0] trim_q;
  logic [14:0] pre_q;
  logic [5:0] sec64_q;
  logic [6:0] div_q;
  logic [hpr_pkg::CTL_WIDTH-1:0] ctl_q;
  logic [hpr_pkg::EV_WIDTH-1:0] mask_q;
  logic [hpr_pkg::EV_WIDTH-1:0] raw_q;
  logic [hpr_pkg::EV_WIDTH-1:0] ev_set;
  logic [hpr_pkg::EV_WIDTH-1:0] ev_clr;
  logic wake_meta_q, wake_sync_q, wake_prev_q;
  logic osc_meta_q, osc_sync_q, osc_prev_q;
  logic bat_meta_q, bat_sync_q;
  logic eq0_q, eq1_q;
  logic eq0, eq1;
  logic osc_rise;
  logic slow_tick;
  logic sec_pulse;
  logic low_bat;
  logic load_wr;
  logic sleep_wr;
  logic veto;
  logic wake_now;
  hpr_pkg::hpr_pwr_t pwr_q;
  logic [4:0] por_q;

  // Address phase is taken when the bus is ready; every transfer then
  // spends one wait cycle so that read data can come from a register.
  assign accept = HSEL && HTRANS[1] && HREADY;
  assign wr_en = dp_q && wr_q;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      dp_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 9'h000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else if (dp_q)
    begin
      dp_q <= 1'b0;
      HREADYOUT <= 1'b1;
    end
    else if (accept)
    begin
      dp_q <= 1'b1;
      wr_q <= HWRITE;
      addr_q <= HADDR[8:0];
      HREADYOUT <= 1'b0;
    end
  end

  // Read data mux; unmapped and write-only addresses read as zero.
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (reg_hit(addr_q, hpr_pkg::OFF_COUNT)) rdata_d = count_q;
    if (reg_hit(addr_q, hpr_pkg::OFF_MATCH0)) rdata_d = match0_q;
    if (reg_hit(addr_q, hpr_pkg::OFF_MATCH1)) rdata_d = match1_q;
    if (reg_hit(addr_q, hpr_pkg::OFF_LOAD)) rdata_d = load_q;
    if (reg_hit(addr_q, hpr_pkg::OFF_CTL)) rdata_d[7:0] = ctl_q;
    if (reg_hit(addr_q, hpr_pkg::OFF_MASK)) rdata_d[3:0] = mask_q;
    if (reg_hit(addr_q, hpr_pkg::OFF_RAW)) rdata_d[3:0] = raw_q;
    if (reg_hit(addr_q, hpr_pkg::OFF_MASKED))
      rdata_d[3:0] = raw_q & mask_q;
    if (reg_hit(addr_q, hpr_pkg::OFF_TRIM)) rdata_d[14:0] = trim_q;
    if (mem_hit(addr_q)) rdata_d = mem_rdata;
  end

  // Read data is loaded in the wait cycle and held until the next read.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      HRDATA <= 32'h0000_0000;
    else if (dp_q && !wr_q)
      HRDATA <= rdata_d;
  end

  // The array reads every cycle at the address phase's address.
  hpr_retain_mem u_mem (
    .clk(CLK),
    .wr_en(wr_en && mem_hit(addr_q)),
    .wr_addr(mem_index(addr_q)),
    .wr_data(HWDATA),
    .rd_addr(mem_index(HADDR[8:0])),
    .rd_data(mem_rdata)
  );

  // Plain configuration registers; a write takes effect at once because
  // the slow rate is only an enable here, so no write gap is needed.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      match0_q <= hpr_pkg::MATCH_RESET;
      match1_q <= hpr_pkg::MATCH_RESET;
      load_q <= hpr_pkg::LOAD_RESET;
      trim_q <= hpr_pkg::TRIM_NOMINAL;
      mask_q <= '0;
      ctl_q <= '0;
    end
    else if (wr_en)
    begin
      if (reg_hit(addr_q, hpr_pkg::OFF_MATCH0)) match0_q <= HWDATA;
      if (reg_hit(addr_q, hpr_pkg::OFF_MATCH1)) match1_q <= HWDATA;
      if (reg_hit(addr_q, hpr_pkg::OFF_LOAD)) load_q <= HWDATA;
      if (reg_hit(addr_q, hpr_pkg::OFF_TRIM)) trim_q <= HWDATA[14:0];
      if (reg_hit(addr_q, hpr_pkg::OFF_MASK))
        mask_q <= HWDATA[hpr_pkg::EV_WIDTH-1:0];
      // The sleep request bit acts as a strobe and is never stored.
      if (reg_hit(addr_q, hpr_pkg::OFF_CTL))
      begin
        ctl_q <= HWDATA[hpr_pkg::CTL_WIDTH-1:0];
        ctl_q[hpr_pkg::CTL_SLEEP_REQUEST] <= 1'b0;
      end
    end
  end

  // Two-flop synchronisers; logic reads the second stage and, for edges, the copy after it.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      wake_meta_q <= 1'b1;
      wake_sync_q <= 1'b1;
      wake_prev_q <= 1'b1;
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      osc_prev_q <= 1'b0;
      bat_meta_q <= 1'b0;
      bat_sync_q <= 1'b0;
    end
    else
    begin
      wake_meta_q <= WAKE_N;
      wake_sync_q <= wake_meta_q;
      wake_prev_q <= wake_sync_q;
      osc_meta_q <= OSC_IN;
      osc_sync_q <= osc_meta_q;
      osc_prev_q <= osc_sync_q;
      bat_meta_q <= BATT_LOW;
      bat_sync_q <= bat_meta_q;
    end
  end

  // Slow tick: every rising edge of a direct oscillator, or every 128th
  // edge of the crystal. A stopped oscillator enable freezes it all.
  assign osc_rise = osc_sync_q && !osc_prev_q;
  assign slow_tick = ctl_q[hpr_pkg::CTL_OSC_ENABLE] && osc_rise &&
                     (ctl_q[hpr_pkg::CTL_OSC_SELECT] ||
                      div_q == hpr_pkg::XTAL_DIV_LAST);

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      div_q <= 7'h00;
    else if (ctl_q[hpr_pkg::CTL_OSC_ENABLE] && osc_rise)
      div_q <= div_q + 7'h01;
  end

  // Predivider counts ticks down; the reload for the first second of each
  // group of 64 is the trim value, the others use the nominal figure.
  assign sec_pulse = slow_tick && ctl_q[hpr_pkg::CTL_COUNTER_ENABLE] &&
                     pre_q == 15'h0000;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pre_q <= hpr_pkg::TRIM_NOMINAL;
      sec64_q <= 6'h00;
    end
    else if (slow_tick && ctl_q[hpr_pkg::CTL_COUNTER_ENABLE])
    begin
      if (pre_q == 15'h0000)
      begin
        sec64_q <= sec64_q + 6'h01;
        pre_q <= (sec64_q == hpr_pkg::TRIM_SLOT_BEFORE) ?
                 trim_q : hpr_pkg::TRIM_NOMINAL;
      end
      else
        pre_q <= pre_q - 15'h0001;
    end
  end

  // Seconds counter; a load write wins over a step in the same cycle.
  assign load_wr = wr_en && reg_hit(addr_q, hpr_pkg::OFF_LOAD);

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      count_q <= 32'h0000_0000;
    else if (load_wr)
      count_q <= HWDATA;
    else if (sec_pulse)
      count_q <= count_q + 32'h0000_0001;
  end

  // Match compare; an event fires when equality first appears.
  assign eq0 = (count_q == match0_q);
  assign eq1 = (count_q == match1_q);

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      eq0_q <= 1'b0;
      eq1_q <= 1'b0;
    end
    else
    begin
      eq0_q <= eq0;
      eq1_q <= eq1;
    end
  end

  // Event sources; a set in the cycle of a clear keeps the flag.
  assign low_bat = ctl_q[hpr_pkg::CTL_LOW_BATTERY_DETECT_ENABLE] &&
                   bat_sync_q;

  always_comb
  begin
    ev_set = '0;
    ev_set[hpr_pkg::EV_MATCH_ZERO] = eq0 && !eq0_q;
    ev_set[hpr_pkg::EV_MATCH_ONE] = eq1 && !eq1_q;
    ev_set[hpr_pkg::EV_BATTERY_LOW] = low_bat;
    ev_set[hpr_pkg::EV_WAKE_PIN] = !wake_sync_q && wake_prev_q;
    ev_clr = '0;
    if (wr_en && reg_hit(addr_q, hpr_pkg::OFF_CLEAR))
      ev_clr = HWDATA[hpr_pkg::EV_WIDTH-1:0];
  end

  // Raw flags survive the processor reset output, so a wake stays seen.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      raw_q <= '0;
    else
      raw_q <= (raw_q & ~ev_clr) | ev_set;
  end

  // One request line for all unmasked pending events.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      IRQ <= 1'b0;
    else
      IRQ <= |(raw_q & mask_q);
  end

  // Power sequencing: run, hibernate, then hold processor reset.
  assign sleep_wr = wr_en && reg_hit(addr_q, hpr_pkg::OFF_CTL) &&
                    HWDATA[hpr_pkg::CTL_SLEEP_REQUEST];
  // The veto is judged on the control word being written, so a write that
  // sets the veto and asks for sleep at once is already refused.
  assign veto = HWDATA[hpr_pkg::CTL_BATTERY_LOW_VETO] &&
                HWDATA[hpr_pkg::CTL_LOW_BATTERY_DETECT_ENABLE] &&
                bat_sync_q;
  assign wake_now =
    (ctl_q[hpr_pkg::CTL_PIN_WAKE_ENABLE] && !wake_sync_q) ||
    (ctl_q[hpr_pkg::CTL_MATCH_WAKE_ENABLE] && (eq0 || eq1));

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pwr_q <= hpr_pkg::PW_RUN;
      REGULATOR_OFF_N <= 1'b1;
      PROC_RST_N <= 1'b1;
      por_q <= 5'h00;
    end
    else
    begin
      unique case (pwr_q)
        hpr_pkg::PW_RUN:
        begin
          if (sleep_wr && !veto)
          begin
            pwr_q <= hpr_pkg::PW_HIB;
            REGULATOR_OFF_N <= 1'b0;
          end
        end
        hpr_pkg::PW_HIB:
        begin
          if (wake_now)
          begin
            pwr_q <= hpr_pkg::PW_POR;
            REGULATOR_OFF_N <= 1'b1;
            PROC_RST_N <= 1'b0;
            por_q <= 5'h00;
          end
        end
        hpr_pkg::PW_POR:
        begin
          if (por_q == 5'(hpr_pkg::POR_CYCLES - 1))
          begin
            pwr_q <= hpr_pkg::PW_RUN;
            PROC_RST_N <= 1'b1;
          end
          else
            por_q <= por_q + 5'h01;
        end
        // The fourth code of the state word is unused; recover to run.
        default:
        begin
          pwr_q <= hpr_pkg::PW_RUN;
        end
      endcase
    end
  end

  // A bus transfer: taken, one wait cycle, then ready.
  sequence s_wait_then_ready;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  a_read_no_gap: assert property (@(posedge CLK) disable iff (!RST_B)
    accept && !HWRITE |=> s_wait_then_ready)
    else $error("read not answered after one wait cycle");

  a_enter_hib: assert property (@(posedge CLK) disable iff (!RST_B)
    pwr_q == hpr_pkg::PW_RUN && sleep_wr && !veto |=> !REGULATOR_OFF_N)
    else $error("sleep request did not switch regulator off");

  a_veto_refuse: assert property (@(posedge CLK) disable iff (!RST_B)
    pwr_q == hpr_pkg::PW_RUN && sleep_wr && veto |=>
      REGULATOR_OFF_N && pwr_q == hpr_pkg::PW_RUN)
    else $error("hibernation entered despite low battery veto");

  sequence s_wake_reset;
    REGULATOR_OFF_N && !PROC_RST_N ##1 !PROC_RST_N;
  endsequence

  a_wake_release: assert property (@(posedge CLK) disable iff (!RST_B)
    pwr_q == hpr_pkg::PW_HIB && wake_now |=> s_wake_reset)
    else $error("wake did not restore regulator and hold reset");

  a_por_keeps_flag: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(PROC_RST_N) && !$past(wake_sync_q) && ev_clr == '0 |->
      raw_q[hpr_pkg::EV_WAKE_PIN] || ctl_q[hpr_pkg::CTL_MATCH_WAKE_ENABLE])
    else $error("wake event lost across reset output");

  a_load_value: assert property (@(posedge CLK) disable iff (!RST_B)
    load_wr |=> count_q == $past(HWDATA))
    else $error("load write did not replace counter");

  a_count_step: assert property (@(posedge CLK) disable iff (!RST_B)
    !load_wr |=> count_q == $past(count_q) + {31'h0, $past(sec_pulse)})
    else $error("counter stepped without a second pulse");

  a_trim_reload: assert property (@(posedge CLK) disable iff (!RST_B)
    sec_pulse && sec64_q == hpr_pkg::TRIM_SLOT_BEFORE |=>
      pre_q == $past(trim_q))
    else $error("trim value not used for the marked second");

  a_osc_gate: assert property (@(posedge CLK) disable iff (!RST_B)
    !ctl_q[hpr_pkg::CTL_OSC_ENABLE] |-> !slow_tick ##1 $stable(div_q))
    else $error("slow clock ran while oscillator disabled");

  a_batt_flag: assert property (@(posedge CLK) disable iff (!RST_B)
    low_bat |=> raw_q[hpr_pkg::EV_BATTERY_LOW])
    else $error("battery low not flagged");

  a_irq_masked: assert property (@(posedge CLK) disable iff (!RST_B)
    ##1 IRQ == |($past(raw_q) & $past(mask_q)))
    else $error("request line disagrees with masked events");

  a_clear_event: assert property (@(posedge CLK) disable iff (!RST_B)
    ev_clr[hpr_pkg::EV_WAKE_PIN] && !ev_set[hpr_pkg::EV_WAKE_PIN] |=>
      !raw_q[hpr_pkg::EV_WAKE_PIN])
    else $error("clear write left event pending");

endmodule

`default_nettype wire

// *** hpr_far_side.sv ***
// Far side model: slow oscillator, wake pin with pull-up, battery sensor.
// Assumes the bench clock; every change lands just after a rising edge.
`default_nettype none

module hpr_far_side (
  input wire logic clk,
  input wire logic osc_run,
  input wire logic wake_req,
  input wire logic batt_req,
  output logic osc_out,
  output logic wake_n,
  output logic batt_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic osc_q = 1'b0;
  logic wake_q = 1'b0;
  logic batt_q = 1'b0;

  // A gated source stands still at low while it is switched off; running,
  // it toggles every clock so that one counted second stays short.
  always @(posedge clk)
  begin
    if (!osc_run)
      osc_q <= 1'b0;
    else
      osc_q <= !osc_q;
  end

  // The wake line has a pull-up, so a released pin reads high.
  always @(posedge clk)
  begin
    wake_q <= wake_req;
    batt_q <= batt_req;
  end

  // Outputs follow the registered levels.
  assign osc_out = osc_q;
  assign wake_n = !wake_q;
  assign batt_low = batt_q;
endmodule

`default_nettype wire

// *** hpr_unit_test.sv ***
// Self-checking bench of the hibernation unit over its AHB-Lite port.
// Assumes the far side model drives the oscillator, wake and battery pins.
`default_nettype none

module hpr_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, osc, wake_n, batt, reg_n, por_n, irq;
  logic osc_run = 1'b0;
  logic wake_req = 1'b0;
  logic batt_req = 1'b0;
  logic rd_ph = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] mem_v[3];
  logic [8:0] madr[3] = '{hpr_pkg::OFF_MEM_FIRST, hpr_pkg::OFF_MEM_LAST,
    9'h074};
  logic [8:0] offs[11] = '{hpr_pkg::OFF_COUNT, hpr_pkg::OFF_MATCH0,
    hpr_pkg::OFF_MATCH1, hpr_pkg::OFF_LOAD, hpr_pkg::OFF_CTL,
    hpr_pkg::OFF_MASK, hpr_pkg::OFF_RAW, hpr_pkg::OFF_MASKED,
    hpr_pkg::OFF_CLEAR, hpr_pkg::OFF_TRIM, 9'h028};
  logic [31:0] rstv[11] = '{32'h0, 32'hffff_ffff, 32'hffff_ffff,
    32'hffff_ffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h7fff, 32'h0};
  logic [31:0] base, v;
  int failures = 0;
  int compares = 0;
  int seed = 32'he12a;
  int n;

  hpr_unit u_dut (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .WAKE_N(wake_n), .OSC_IN(osc), .BATT_LOW(batt),
    .REGULATOR_OFF_N(reg_n), .PROC_RST_N(por_n), .IRQ(irq));

  hpr_far_side u_far (.clk(clk), .osc_run(osc_run), .wake_req(wake_req),
    .batt_req(batt_req), .osc_out(osc), .wake_n(wake_n), .batt_low(batt));

  // Free-running 25 MHz clock.
  initial
  begin
    forever #20 clk = !clk;
  end

  function automatic logic [31:0] bitv(input int b);
    return 32'h1 << b;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Waits for ready under a bound, so a stuck slave cannot hang the run.
  task automatic ready_wait;
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hready !== 1'b1 && k < 64);
    if (k >= 64)
      failures++;
  endtask

  // One single word transfer; transfers never overlap, since each one
  // waits for ready after its address phase and again after its data phase.
  task automatic bus(input logic [8:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {23'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    ready_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    ready_wait();
    rd_ph <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic wait_reg(input logic e);
    n = 0;
    while (reg_n !== e && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check({31'h0, reg_n}, {31'h0, e});
  endtask

  // Each completed read retires the oldest expectation.
  always @(posedge clk)
    if (rd_ph && hready === 1'b1)
      check(hrdata, exp_q.pop_front());

  // Watchdog sized beyond the one counted second plus the other tests.
  initial
  begin
    repeat (80000) @(posedge clk);
    failures++;
    results();
  end

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    check({30'h0, reg_n, por_n}, 32'h3);
    check({31'h0, hresp}, 32'h0);
    for (int i = 0; i < 11; i++)
      rd(offs[i], rstv[i]);
    $display("Test reset values done");
    base = bitv(hpr_pkg::CTL_OSC_ENABLE) | bitv(hpr_pkg::CTL_OSC_SELECT);
    wr_ctl: bus(hpr_pkg::OFF_CTL, 1'b1, base);
    osc_run <= 1'b1;
    rd(hpr_pkg::OFF_CTL, base);
    for (int i = 0; i < 3; i++)
    begin
      mem_v[i] = $random(seed);
      bus(madr[i], 1'b1, mem_v[i]);
      rd(madr[i], mem_v[i]);
    end
    v = $random(seed) & 32'h7fff;
    bus(hpr_pkg::OFF_TRIM, 1'b1, v);
    rd(hpr_pkg::OFF_TRIM, v);
    $display("Test memory and trim done");
    for (int i = 0; i < 2; i++)
    begin
      v = $random(seed);
      bus(i ? hpr_pkg::OFF_MATCH1 : hpr_pkg::OFF_MATCH0, 1'b1, v);
      bus(hpr_pkg::OFF_LOAD, 1'b1, v);
      rd(hpr_pkg::OFF_LOAD, v);
      rd(hpr_pkg::OFF_RAW, bitv(i));
      rd(hpr_pkg::OFF_MASKED, 32'h0);
      rd(hpr_pkg::OFF_COUNT, v);
      check({31'h0, irq}, 32'h0);
      bus(hpr_pkg::OFF_MASK, 1'b1, bitv(i));
      rd(hpr_pkg::OFF_MASKED, bitv(i));
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      bus(hpr_pkg::OFF_CLEAR, 1'b1, bitv(i));
      rd(hpr_pkg::OFF_RAW, 32'h0);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
    end
    bus(hpr_pkg::OFF_MASK, 1'b1, 32'h0);
    $display("Test match events done");
    batt_req <= 1'b1;
    repeat (8) @(posedge clk);
    rd(hpr_pkg::OFF_RAW, 32'h0);
    base = base | bitv(hpr_pkg::CTL_LOW_BATTERY_DETECT_ENABLE);
    bus(hpr_pkg::OFF_CTL, 1'b1, base);
    repeat (8) @(posedge clk);
    rd(hpr_pkg::OFF_RAW, bitv(hpr_pkg::EV_BATTERY_LOW));
    v = bitv(hpr_pkg::CTL_BATTERY_LOW_VETO);
    v = v | bitv(hpr_pkg::CTL_PIN_WAKE_ENABLE);
    bus(hpr_pkg::OFF_CTL, 1'b1, base | v | bitv(hpr_pkg::CTL_SLEEP_REQUEST));
    repeat (10) @(posedge clk);
    check({31'h0, reg_n}, 32'h1);
    batt_req <= 1'b0;
    repeat (8) @(posedge clk);
    bus(hpr_pkg::OFF_CLEAR, 1'b1, bitv(hpr_pkg::EV_BATTERY_LOW));
    rd(hpr_pkg::OFF_RAW, 32'h0);
    $display("Test battery veto done");
    // A wake source is armed in the same write that asks for sleep.
    v = bitv(hpr_pkg::CTL_PIN_WAKE_ENABLE);
    bus(hpr_pkg::OFF_CTL, 1'b1, base | v | bitv(hpr_pkg::CTL_SLEEP_REQUEST));
    wait_reg(1'b0);
    wake_req <= 1'b1;
    wait_reg(1'b1);
    n = 0;
    while (por_n !== 1'b0 && n < 10)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (por_n === 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    check(32'(n), 32'(hpr_pkg::POR_CYCLES));
    wake_req <= 1'b0;
    rd(hpr_pkg::OFF_RAW, bitv(hpr_pkg::EV_WAKE_PIN));
    for (int i = 0; i < 3; i++)
      rd(madr[i], mem_v[i]);
    bus(hpr_pkg::OFF_CLEAR, 1'b1, bitv(hpr_pkg::EV_WAKE_PIN));
    $display("Test pin wake done");
    bus(hpr_pkg::OFF_MATCH0, 1'b1, 32'h100);
    bus(hpr_pkg::OFF_LOAD, 1'b1, 32'hff);
    v = bitv(hpr_pkg::CTL_MATCH_WAKE_ENABLE);
    bus(hpr_pkg::OFF_CTL, 1'b1, base | v | bitv(hpr_pkg::CTL_SLEEP_REQUEST));
    wait_reg(1'b0);
    bus(hpr_pkg::OFF_LOAD, 1'b1, 32'h100);
    wait_reg(1'b1);
    rd(hpr_pkg::OFF_RAW, bitv(hpr_pkg::EV_MATCH_ZERO));
    $display("Test match wake done");
    // One tick every two clocks: 32768 ticks make the first second.
    bus(hpr_pkg::OFF_LOAD, 1'b1, 32'h10);
    v = bitv(hpr_pkg::CTL_COUNTER_ENABLE);
    bus(hpr_pkg::OFF_CTL, 1'b1, base | v);
    repeat (64000) @(posedge clk);
    rd(hpr_pkg::OFF_COUNT, 32'h10);
    repeat (2000) @(posedge clk);
    rd(hpr_pkg::OFF_COUNT, 32'h11);
    $display("Test seconds counter done");
    results();
  end
endmodule

`default_nettype wire
